// ---- ppu_group.sv ----
// Purpose: per-group trigger selection and transfer mask
// Assumes: match pulses are one clock wide and synchronous
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module ppu_group
  import ppu_pkg::*;
#(
  parameter int NUM_CH = PPU_NUM_CH,
  parameter int GRP_W = PPU_GRP_W
) (
  input wire ppu_grp_cfg_s cfg_i,
  input wire logic [NUM_CH-1:0] cmp_a_i,
  input wire logic [NUM_CH-1:0] cmp_b_i,
  input wire logic [GRP_W-1:0] enable_i,
  input wire logic [GRP_W-1:0] next_i,
  output logic [GRP_W-1:0] load_o
);

  wire hit_a;
  wire hit_b;
  wire [GRP_W-1:0] mask_a;
  wire [GRP_W-1:0] mask_b;

  assign hit_a = cmp_a_i[cfg_i.sel]; // R4 R5 R18
  assign hit_b = cmp_b_i[cfg_i.sel] & cfg_i.nonoverlap; // R8
  assign mask_a = hit_a ? enable_i : '0; // R3 R12 R15
  assign mask_b = hit_b ? (enable_i & ~next_i) : '0; // R13
  assign load_o = mask_a | mask_b; // R17

endmodule : ppu_group

// ---- ppu_pkg.sv ----
// Purpose: constants, register map and carrier types of the pattern pulse unit
// Assumes: 8-bit register port, 16 pattern pins in four 4-bit groups
// Notes: trigger pulses come from the timer unit, one clock wide
// Contract
// (R1) same trigger for groups 0 and 1: all eight low next bits at one address
// (R2) different triggers: nibbles at two addresses, unused nibble reads ones, ignores writes
// (R3) selected trigger copies the group's enabled next bits into the output pattern
// (R4) group 3 trigger select at bits 7:6, reset 11, channel 0 to 3
// (R5) group 2 trigger select at bits 5:4, reset 11, channel 0 to 3
// (R6) polarity bit 7 for group 3, bit 6 for group 2, reset 1, 0 inverts
// (R7) inverted group drives pin low for pattern 1 and high for pattern 0
// (R8) nonoverlap bit 3 for group 3, bit 2 for group 2, reset 0
// (R9) pin is driven only when direction bit and enable bit are both 1
// (R10) the output pattern value drives the pin before any trigger
// (R11) software loads the next pattern before the next trigger
// (R12) nonoverlap mode: match A copies every enabled next bit
// (R13) nonoverlap mode: match B copies only enabled next bits holding 0
// (R14) nonoverlap mode: software leaves next pattern alone between match B and A
// (R15) only bits whose enable is 1 are ever copied by a trigger
// (R16) output pattern bit ignores software writes while its enable is set
// (R17) transfer happens on every trigger regardless of pin usage
// (R18) timer gives match A and B as one-clock pulses on this clock
package ppu_pkg;

  localparam int PPU_ADDR_W = 4;
  localparam int PPU_DATA_W = 8;
  localparam int PPU_NUM_GRP = 4;
  localparam int PPU_NUM_CH = 4;
  localparam int PPU_GRP_W = 4;
  localparam int PPU_PIN_W = 16;
  localparam int PPU_SEL_W = 2;

  // register offsets
  localparam logic [3:0] PPU_OFS_ENA_HI = 4'h0;
  localparam logic [3:0] PPU_OFS_ENA_LO = 4'h1;
  localparam logic [3:0] PPU_OFS_OUT_HI = 4'h2;
  localparam logic [3:0] PPU_OFS_OUT_LO = 4'h3;
  localparam logic [3:0] PPU_OFS_NEXT_HI = 4'h4;
  localparam logic [3:0] PPU_OFS_NEXT_LO = 4'h5;
  localparam logic [3:0] PPU_OFS_NEXT_HI_ALT = 4'h6;
  localparam logic [3:0] PPU_OFS_NEXT_LO_ALT = 4'h7;
  localparam logic [3:0] PPU_OFS_TRIG_SEL = 4'h8;
  localparam logic [3:0] PPU_OFS_MODE = 4'h9;
  localparam logic [3:0] PPU_OFS_DIR_HI = 4'hA;
  localparam logic [3:0] PPU_OFS_DIR_LO = 4'hB;

  // field positions: group g uses select bits 2g+1:2g; groups 2 and 3 also use polarity bit 4+g, nonoverlap bit g
  localparam int PPU_POL_BASE = 4;
  localparam int PPU_NOV_BASE = 0;
  localparam int PPU_MODE_GRP_LO = 2;

  // reset values
  localparam logic [7:0] PPU_RST_TRIG_SEL = 8'hFF;
  localparam logic [7:0] PPU_RST_MODE = 8'hF0;
  localparam logic [7:0] PPU_RST_ZERO = 8'h00;
  localparam logic [15:0] PPU_RST_PINS = 16'h0000;
  localparam logic [3:0] PPU_NIB_ONES = 4'hF;
  localparam logic [7:0] PPU_READ_UNMAPPED = 8'h00;

  typedef struct packed {
    logic [PPU_SEL_W-1:0] sel;
    logic polarity;
    logic nonoverlap;
  } ppu_grp_cfg_s;

endpackage : ppu_pkg

// ---- ppu_properties.sv ----
// Purpose: port checker of the pattern pulse unit
// Assumes: ce_i held high; shadows follow port writes
// Notes: bound into ppu_top below
`timescale 1ns/1ps
module ppu_properties
  import ppu_pkg::*;
#(parameter int NUM_CH = PPU_NUM_CH) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [PPU_ADDR_W-1:0] addr_i,
  input wire logic [PPU_DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [PPU_DATA_W-1:0] rdata_o,
  input wire logic [NUM_CH-1:0] cmp_a_i,
  input wire logic [NUM_CH-1:0] cmp_b_i,
  input wire logic [PPU_PIN_W-1:0] pulse_o,
  input wire logic [PPU_PIN_W-1:0] pulse_oe_n_o
);
  logic [7:0] sel_q, mode_q;
  logic [15:0] ena_q;
  wire same = sel_q[3:2] == sel_q[1:0];
  wire rd_lo = re_i && addr_i == PPU_OFS_NEXT_LO;
  wire trig = (cmp_a_i | cmp_b_i) != '0;
  wire b_only = cmp_b_i != '0 && cmp_a_i == '0 && !we_i;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {sel_q, mode_q, ena_q} <= {PPU_RST_TRIG_SEL, PPU_RST_MODE, 16'h0000};
    end else if (we_i) begin
      sel_q <= (addr_i == PPU_OFS_TRIG_SEL) ? wdata_i : sel_q;
      mode_q <= (addr_i == PPU_OFS_MODE) ? wdata_i : mode_q;
      ena_q[15:8] <= (addr_i == PPU_OFS_ENA_HI) ? wdata_i : ena_q[15:8];
      ena_q[7:0] <= (addr_i == PPU_OFS_ENA_LO) ? wdata_i : ena_q[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_VIEW_FULL: assert property (we_i && addr_i == PPU_OFS_NEXT_LO && same ##1 !we_i ##1 rd_lo
    |=> rdata_o == $past(wdata_i, 3)) else $error("full next view mismatch");
  AST_VIEW_HI: assert property (rd_lo && !same |=> rdata_o[3:0] == PPU_NIB_ONES)
    else $error("hidden low nibble not ones");
  AST_VIEW_LO: assert property (re_i && addr_i == PPU_OFS_NEXT_LO_ALT && !same |=> rdata_o[7:4] == PPU_NIB_ONES)
    else $error("hidden high nibble not ones");
  AST_PIN_CAUSE: assert property ($changed(pulse_o) |-> $past(we_i, 2) || $past(trig, 2))
    else $error("pins moved without cause");
  AST_OE_GATE: assert property ((~pulse_oe_n_o & ~$past(ena_q)) == '0)
    else $error("pin driven while disabled");
  AST_ENA_GATE: assert property (!$past(we_i, 2) |-> ((pulse_o ^ $past(pulse_o)) & ~$past(ena_q, 2)) == '0)
    else $error("disabled bit moved");
  AST_NORMAL_B: assert property (b_only && !mode_q[3] |=> ##1 $stable(pulse_o[15:12]))
    else $error("match B moved normal group");
  AST_NOV_B: assert property (b_only && mode_q[3] && mode_q[7] |=> ##1 (pulse_o[15:12] & ~$past(pulse_o[15:12])) == 4'h0)
    else $error("match B raised a pin");
endmodule : ppu_properties
bind ppu_top ppu_properties #(.NUM_CH(NUM_CH)) ppu_properties_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .cmp_a_i(cmp_a_i),
  .cmp_b_i(cmp_b_i), .pulse_o(pulse_o), .pulse_oe_n_o(pulse_oe_n_o));

// ---- ppu_timer_model.sv ----
// Purpose: timer unit stand-in that issues compare match pulses
// Assumes: the bench raises one request bit per wanted match for one cycle
// Notes: bits 3:0 request match A, bits 7:4 match B
`timescale 1ns/1ps
module ppu_timer_model
  import ppu_pkg::*;
(
  input wire logic clk_i,
  input wire logic [2*PPU_NUM_CH-1:0] fire_i,
  output logic [PPU_NUM_CH-1:0] cmp_a_o,
  output logic [PPU_NUM_CH-1:0] cmp_b_o
);
  // one clock wide, aligned to the unit clock
  always_ff @(posedge clk_i) begin
    {cmp_b_o, cmp_a_o} <= fire_i;
  end
endmodule : ppu_timer_model

// ---- ppu_top.sv ----
// Purpose: pattern pulse unit, register port, transfer and pin drive
// Assumes: register port reads answer one cycle later; ce_i low freezes all state
// Notes: pins follow the output pattern with one cycle of register delay
`timescale 1ns/1ps
module ppu_top
  import ppu_pkg::*;
#(
  parameter int NUM_CH = PPU_NUM_CH
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [PPU_ADDR_W-1:0] addr_i,
  input wire logic [PPU_DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [PPU_DATA_W-1:0] rdata_o,
  input wire logic [NUM_CH-1:0] cmp_a_i,
  input wire logic [NUM_CH-1:0] cmp_b_i,
  output logic [PPU_PIN_W-1:0] pulse_o,
  output logic [PPU_PIN_W-1:0] pulse_oe_n_o
);

  // view of one next-pattern byte at an address; hidden nibble reads ones
  function automatic logic [7:0] next_view(input logic [7:0] data, input logic same, input logic prim);
    logic [7:0] v;
    v = '1;
    if (same) begin
      v = prim ? data : '1;
    end else begin
      v = prim ? {data[7:4], PPU_NIB_ONES} : {PPU_NIB_ONES, data[3:0]};
    end
    return v;
  endfunction : next_view

  // writable bits of one next-pattern byte for a given address
  function automatic logic [7:0] next_wmask(input logic same, input logic prim, input logic alt);
    logic [7:0] m;
    m = '0;
    if (same) begin
      m = prim ? 8'hFF : 8'h00;
    end else if (prim) begin
      m = 8'hF0;
    end else if (alt) begin
      m = 8'h0F;
    end
    return m;
  endfunction : next_wmask

  // merge write data into a register under a bit mask
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
    return (old & ~m) | (wd & m);
  endfunction : merge

  logic [PPU_PIN_W-1:0] ena_q, ena_d;
  logic [PPU_PIN_W-1:0] out_q, out_d;
  logic [PPU_PIN_W-1:0] next_q, next_d;
  logic [PPU_PIN_W-1:0] dir_q, dir_d;
  logic [7:0] trig_sel_q, trig_sel_d;
  logic [7:0] mode_q, mode_d;
  logic [PPU_DATA_W-1:0] rdata_q, rdata_d;
  logic [PPU_PIN_W-1:0] pin_q, pin_d;
  logic [PPU_PIN_W-1:0] oe_n_q, oe_n_d;

  ppu_grp_cfg_s grp_cfg [PPU_NUM_GRP];
  wire [PPU_PIN_W-1:0] load;
  wire [PPU_PIN_W-1:0] pol_mask;

  // address decode
  wire wr_ena_hi = we_i && (addr_i == PPU_OFS_ENA_HI);
  wire wr_ena_lo = we_i && (addr_i == PPU_OFS_ENA_LO);
  wire wr_out_hi = we_i && (addr_i == PPU_OFS_OUT_HI);
  wire wr_out_lo = we_i && (addr_i == PPU_OFS_OUT_LO);
  wire wr_next_hi = we_i && (addr_i == PPU_OFS_NEXT_HI);
  wire wr_next_lo = we_i && (addr_i == PPU_OFS_NEXT_LO);
  wire wr_next_hi_alt = we_i && (addr_i == PPU_OFS_NEXT_HI_ALT);
  wire wr_next_lo_alt = we_i && (addr_i == PPU_OFS_NEXT_LO_ALT);
  wire wr_trig = we_i && (addr_i == PPU_OFS_TRIG_SEL);
  wire wr_mode = we_i && (addr_i == PPU_OFS_MODE);
  wire wr_dir_hi = we_i && (addr_i == PPU_OFS_DIR_HI);
  wire wr_dir_lo = we_i && (addr_i == PPU_OFS_DIR_LO);

  // groups sharing a trigger see one combined byte
  wire same_hi = (trig_sel_q[7:6] == trig_sel_q[5:4]);
  wire same_lo = (trig_sel_q[3:2] == trig_sel_q[1:0]);

  wire [7:0] next_wm_hi = next_wmask(same_hi, wr_next_hi, wr_next_hi_alt); // R2
  wire [7:0] next_wm_lo = next_wmask(same_lo, wr_next_lo, wr_next_lo_alt); // R1 R2

  // software may only write output pattern bits whose enable is clear
  wire [7:0] out_wm_hi = wr_out_hi ? ~ena_q[15:8] : 8'h00; // R16
  wire [7:0] out_wm_lo = wr_out_lo ? ~ena_q[7:0] : 8'h00; // R16

  // group configuration; low groups are fixed direct and normal
  genvar g;
  generate
    for (g = 0; g < PPU_NUM_GRP; g++) begin : gen_grp
      if (g >= PPU_MODE_GRP_LO) begin : gen_mode
        assign grp_cfg[g].polarity = mode_q[PPU_POL_BASE+g]; // R6
        assign grp_cfg[g].nonoverlap = mode_q[PPU_NOV_BASE+g]; // R8
      end else begin : gen_fixed
        assign grp_cfg[g].polarity = 1'b1;
        assign grp_cfg[g].nonoverlap = 1'b0;
      end
      assign grp_cfg[g].sel = trig_sel_q[PPU_SEL_W*g +: PPU_SEL_W]; // R4 R5
      assign pol_mask[PPU_GRP_W*g +: PPU_GRP_W] = {PPU_GRP_W{~grp_cfg[g].polarity}};

      ppu_group #(
        .NUM_CH(NUM_CH),
        .GRP_W(PPU_GRP_W)
      ) u_group (
        .cfg_i(grp_cfg[g]),
        .cmp_a_i(cmp_a_i),
        .cmp_b_i(cmp_b_i),
        .enable_i(ena_q[PPU_GRP_W*g +: PPU_GRP_W]),
        .next_i(next_q[PPU_GRP_W*g +: PPU_GRP_W]),
        .load_o(load[PPU_GRP_W*g +: PPU_GRP_W])
      );
    end
  endgenerate

  // register next values
  assign ena_d = {wr_ena_hi ? wdata_i : ena_q[15:8], wr_ena_lo ? wdata_i : ena_q[7:0]};
  assign dir_d = {wr_dir_hi ? wdata_i : dir_q[15:8], wr_dir_lo ? wdata_i : dir_q[7:0]};
  assign trig_sel_d = wr_trig ? wdata_i : trig_sel_q;
  assign mode_d = wr_mode ? wdata_i : mode_q;
  assign next_d = {merge(next_q[15:8], wdata_i, next_wm_hi), merge(next_q[7:0], wdata_i, next_wm_lo)}; // R1 R2

  // trigger transfer takes the old next value even when a write lands in the same cycle
  wire [PPU_PIN_W-1:0] out_sw = {merge(out_q[15:8], wdata_i, out_wm_hi), merge(out_q[7:0], wdata_i, out_wm_lo)};
  assign out_d = (out_sw & ~load) | (next_q & load); // R3 R12 R13 R15 R17

  // pin drive follows the stored pattern from reset on
  assign pin_d = out_q ^ pol_mask; // R7 R10
  assign oe_n_d = ~(dir_q & ena_q); // R9

  // read mux
  always_comb begin
    rdata_d = PPU_READ_UNMAPPED;
    if (re_i) begin
      case (addr_i)
        PPU_OFS_ENA_HI: rdata_d = ena_q[15:8];
        PPU_OFS_ENA_LO: rdata_d = ena_q[7:0];
        PPU_OFS_OUT_HI: rdata_d = out_q[15:8];
        PPU_OFS_OUT_LO: rdata_d = out_q[7:0];
        PPU_OFS_NEXT_HI: rdata_d = next_view(next_q[15:8], same_hi, 1'b1); // R2
        PPU_OFS_NEXT_LO: rdata_d = next_view(next_q[7:0], same_lo, 1'b1); // R1 R2
        PPU_OFS_NEXT_HI_ALT: rdata_d = next_view(next_q[15:8], same_hi, 1'b0); // R2
        PPU_OFS_NEXT_LO_ALT: rdata_d = next_view(next_q[7:0], same_lo, 1'b0); // R2
        PPU_OFS_TRIG_SEL: rdata_d = trig_sel_q;
        PPU_OFS_MODE: rdata_d = mode_q;
        PPU_OFS_DIR_HI: rdata_d = dir_q[15:8];
        PPU_OFS_DIR_LO: rdata_d = dir_q[7:0];
        default: rdata_d = PPU_READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ena_q <= PPU_RST_PINS;
      out_q <= PPU_RST_PINS;
      next_q <= PPU_RST_PINS;
      dir_q <= PPU_RST_PINS;
      trig_sel_q <= PPU_RST_TRIG_SEL;
      mode_q <= PPU_RST_MODE;
    end else if (ce_i) begin
      ena_q <= ena_d;
      out_q <= out_d;
      next_q <= next_d;
      dir_q <= dir_d;
      trig_sel_q <= trig_sel_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= PPU_RST_ZERO;
      pin_q <= PPU_RST_PINS;
      oe_n_q <= ~PPU_RST_PINS;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign rdata_o = rdata_q;
  assign pulse_o = pin_q;
  assign pulse_oe_n_o = oe_n_q;

endmodule : ppu_top

// ---- testbench.sv ----
// Purpose: self-checking bench of the pattern pulse unit
// Assumes: ce_i dropped only while no register write is made; timer model supplies match pulses
// Notes: high byte groups carry the transfer scenarios
`timescale 1ns/1ps
module testbench
  import ppu_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic we = 1'b0, re = 1'b0, ce = 1'b1;
  logic [3:0] addr = 4'h0, cmp_a, cmp_b;
  logic [7:0] wdata = 8'h00, req = 8'h00, rdata;
  logic [15:0] pins, oe_n;
  int fails = 0, check_count = 0;
  always #5 clk_i = ~clk_i;
  ppu_top ppu_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .cmp_a_i(cmp_a), .cmp_b_i(cmp_b), .pulse_o(pins), .pulse_oe_n_o(oe_n));
  ppu_timer_model ppu_timer_model_i (.clk_i(clk_i), .fire_i(req), .cmp_a_o(cmp_a), .cmp_b_o(cmp_b));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1;
    chk("rdata", {8'h00, rdata}, {8'h00, exp});
  endtask : rd
  // match B request in the upper half, match A in the lower
  task automatic fire(input logic [7:0] ba);
    @(posedge clk_i);
    req <= ba;
    @(posedge clk_i);
    req <= 8'h00;
    repeat (3) @(posedge clk_i);
  endtask : fire
  task automatic t_reset;
    rd(PPU_OFS_TRIG_SEL, 8'hFF);
    rd(PPU_OFS_MODE, 8'hF0);
    rd(4'hC, 8'h00);
    chk("oe_n", oe_n, 16'hFFFF);
  endtask : t_reset
  task automatic t_view;
    wr(PPU_OFS_NEXT_LO, 8'hA5);
    rd(PPU_OFS_NEXT_LO, 8'hA5);
    wr(PPU_OFS_TRIG_SEL, 8'hF4);
    wr(PPU_OFS_NEXT_LO, 8'h3C);
    rd(PPU_OFS_NEXT_LO, 8'h3F);
    wr(PPU_OFS_NEXT_LO_ALT, 8'hC6);
    rd(PPU_OFS_NEXT_LO_ALT, 8'hF6);
    wr(PPU_OFS_TRIG_SEL, 8'hFF);
    rd(PPU_OFS_NEXT_LO, 8'h36);
    // high groups on different triggers: each nibble at its own address
    wr(PPU_OFS_TRIG_SEL, 8'hBF);
    wr(PPU_OFS_NEXT_HI_ALT, 8'h12);
    rd(PPU_OFS_NEXT_HI_ALT, 8'hF2);
    wr(PPU_OFS_NEXT_HI, 8'h9C);
    rd(PPU_OFS_NEXT_HI, 8'h9F);
    wr(PPU_OFS_TRIG_SEL, 8'hFF);
    rd(PPU_OFS_NEXT_HI, 8'h92);
  endtask : t_view
  task automatic t_sel;
    wr(PPU_OFS_DIR_HI, 8'hFF);
    wr(PPU_OFS_OUT_HI, 8'h5A);
    repeat (2) @(posedge clk_i);
    chk("pins", pins, 16'h5A00);
    chk("oe_n", oe_n, 16'hFFFF);
    wr(PPU_OFS_ENA_HI, 8'hFC);
    wr(PPU_OFS_OUT_HI, 8'h00);
    rd(PPU_OFS_OUT_HI, 8'h58);
    chk("oe_n", oe_n, 16'h03FF);
    for (int ch = 0; ch < 4; ch++) begin
      wr(PPU_OFS_TRIG_SEL, {2'(ch), 2'(ch), 4'hF});
      wr(PPU_OFS_NEXT_HI, {4'(ch + 1), 4'hF});
      fire({4'h0, 4'h1 << ((ch + 1) % 4)});
      rd(PPU_OFS_OUT_HI, (ch == 0) ? 8'h58 : {4'(ch), 4'hC});
      fire({4'h0, 4'h1 << ch});
      rd(PPU_OFS_OUT_HI, {4'(ch + 1), 4'hC});
    end
    fire(8'h80);
    rd(PPU_OFS_OUT_HI, 8'h4C);
    chk("pins", pins, 16'h4C00);
  endtask : t_sel
  task automatic t_nov;
    wr(PPU_OFS_MODE, 8'hFC);
    wr(PPU_OFS_NEXT_HI, 8'hA5);
    fire(8'h80);
    rd(PPU_OFS_OUT_HI, 8'h04);
    fire(8'h08);
    rd(PPU_OFS_OUT_HI, 8'hA4);
    wr(PPU_OFS_MODE, 8'h3C);
    repeat (2) @(posedge clk_i);
    chk("pins", pins, 16'h5B00);
  endtask : t_nov
  // a trigger that arrives while the clock enable is low must not move anything
  task automatic t_hold;
    wr(PPU_OFS_NEXT_HI, 8'h30);
    @(posedge clk_i);
    ce <= 1'b0;
    fire(8'h08);
    ce <= 1'b1;
    rd(PPU_OFS_OUT_HI, 8'hA4);
    fire(8'h08);
    rd(PPU_OFS_OUT_HI, 8'h30);
    chk("pins", pins, 16'hCF00);
  endtask : t_hold
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_view();
    t_sel();
    t_nov();
    t_hold();
    report_and_stop();
  end
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule : testbench
